// ### src/gsp_pkg.sv
package gsp_pkg;
  localparam int GSP_STAGES = 8;
  localparam int GSP_FIFO_DEPTH = 32;
  localparam logic [GSP_STAGES-1:0] GSP_STAGE_RESET = 8'h00;
endpackage

// ### src/gsp_shifter.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module gsp_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic flush_b_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready_out = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem_ff[rd_ptr_ff];

  // Storage needs no reset; the count alone decides what is valid.
  always_ff @(posedge ref_clk_in)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  // A clear empties the queue as well, so no stale bit reaches the chain later.
  always_ff @(posedge ref_clk_in or negedge rst_b_in or negedge flush_b_in)
  begin
    if (!rst_b_in || !flush_b_in)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // gsp_fifo

////////////////////////////////////////////////////////////////////////////////

module gsp_shifter #(
  parameter int STAGES = gsp_pkg::GSP_STAGES,
  parameter int FIFO_DEPTH = gsp_pkg::GSP_FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic ser_a_in,
  input wire logic ser_b_in,
  input wire logic shift_clk_in,
  input wire logic zero_all_n_in,
  input wire logic stage_ready_in,
  output logic shift_ready_out,
  output logic [gsp_pkg::GSP_STAGES-1:0] stage_outputs_out
);
  import gsp_pkg::*;

  logic shift_clk_prev_ff;
  logic [STAGES-1:0] chain_ff;
  logic shift_rise;
  logic gated_bit;
  logic push;
  logic head_valid;
  logic head_bit;
  logic advance;

  ////////////////////////////////////////////////////////////////////////////////

  assign gated_bit = ser_a_in & ser_b_in;
  assign shift_rise = shift_clk_in && !shift_clk_prev_ff;
  assign push = shift_rise && shift_ready_out;
  assign advance = head_valid && stage_ready_in;

  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      shift_clk_prev_ff <= 1'b0;
    end
    else
    begin
      shift_clk_prev_ff <= shift_clk_in;
    end
  end

  // A shift edge seen while the queue is full is dropped; the driver must
  // watch shift_ready_out, since the chain may be held by its consumer.
  gsp_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .flush_b_in(zero_all_n_in),
    .in_valid_in(shift_rise),
    .in_ready_out(shift_ready_out),
    .in_data_in(gated_bit),
    .out_valid_out(head_valid),
    .out_ready_in(stage_ready_in),
    .out_data_out(head_bit)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // Reset gives the chain a known value, so outputs are defined even if the
  // driver never pulses the clear.
  always_ff @(posedge ref_clk_in or negedge rst_b_in or negedge zero_all_n_in)
  begin
    if (!rst_b_in || !zero_all_n_in)
    begin
      chain_ff <= GSP_STAGE_RESET;
    end
    else if (advance)
    begin
      chain_ff <= {chain_ff[STAGES-2:0], head_bit};
    end
  end

  assign stage_outputs_out = chain_ff;

  ////////////////////////////////////////////////////////////////////////////////

  // The bit must reach the first stage, not merely leave the gate.
  property p_and_gate;
    @(posedge ref_clk_in) disable iff (!rst_b_in || !zero_all_n_in)
    (push && !head_valid) ##1 stage_ready_in
      |=> (stage_outputs_out[0] == $past(ser_a_in && ser_b_in, 2));
  endproperty
  a_and_gate: assert property (p_and_gate) else $error("gated bit not A and B");

  property p_low_blocks;
    @(posedge ref_clk_in) disable iff (!rst_b_in || !zero_all_n_in)
    (push && (!ser_a_in || !ser_b_in) && !head_valid) ##1 stage_ready_in
      |=> !stage_outputs_out[0];
  endproperty
  a_low_blocks: assert property (p_low_blocks) else $error("low input did not load zero");

  property p_high_passes;
    @(posedge ref_clk_in) disable iff (!rst_b_in || !zero_all_n_in)
    (push && ser_a_in && !head_valid) ##1 (stage_ready_in && zero_all_n_in)
      |=> (stage_outputs_out[0] == $past(ser_b_in, 2));
  endproperty
  a_high_passes: assert property (p_high_passes) else $error("other input not passed");

  property p_hold;
    @(posedge ref_clk_in) disable iff (!rst_b_in || !zero_all_n_in)
    !advance |=> $stable(stage_outputs_out);
  endproperty
  a_hold: assert property (p_hold) else $error("stages changed without a shift");

  property p_stall_hold;
    @(posedge ref_clk_in) disable iff (!rst_b_in || !zero_all_n_in)
    !stage_ready_in |=> $stable(stage_outputs_out);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stages moved while stalled");

  property p_clear_holds;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    !zero_all_n_in |-> (stage_outputs_out == '0) && !head_valid;
  endproperty
  a_clear_holds: assert property (p_clear_holds) else $error("clear did not hold zero");

  property p_outputs;
    @(posedge ref_clk_in) disable iff (!rst_b_in || !zero_all_n_in)
    (advance && head_bit) ##1 (!advance [*2]) |=> stage_outputs_out[0];
  endproperty
  a_outputs: assert property (p_outputs) else $error("stored bit not retained");

  property p_move;
    @(posedge ref_clk_in) disable iff (!rst_b_in || !zero_all_n_in)
    advance |=> (stage_outputs_out[STAGES-1:1] == $past(stage_outputs_out[STAGES-2:0]));
  endproperty
  a_move: assert property (p_move) else $error("stage did not take predecessor");

  property p_drop;
    @(posedge ref_clk_in) disable iff (!rst_b_in || !zero_all_n_in)
    advance |=> (stage_outputs_out[0] == $past(head_bit));
  endproperty
  a_drop: assert property (p_drop) else $error("first stage wrong after shift");

  property p_clear_now;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    $fell(zero_all_n_in) |-> (stage_outputs_out == '0) && shift_ready_out;
  endproperty
  a_clear_now: assert property (p_clear_now) else $error("clear not immediate");
endmodule // gsp_shifter

// ### verification/gsp_gpio.sv
`timescale 1ns/1ps

module gsp_gpio (
  input wire logic ref_clk_in,
  output logic ser_a_out,
  output logic ser_b_out,
  output logic shift_clk_out,
  output logic zero_all_n_out
);
  initial
  begin
    ser_a_out = 1'b0;
    ser_b_out = 1'b1;
    shift_clk_out = 1'b0;
    zero_all_n_out = 1'b0;
  end
  // Data lines flip once held past the edge, so a stale level never looks valid.
  task automatic push(input logic a, input logic b);
    ser_a_out = a;
    ser_b_out = b;
    shift_clk_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    shift_clk_out = 1'b0;
    ser_a_out = ~a;
    ser_b_out = ~b;
  endtask
endmodule // gsp_gpio

// ### verification/gsp_shifter_bench.sv
`timescale 1ns/1ps

module gsp_shifter_bench;
  import gsp_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic stage_ready_in = 1'b1;
  logic ser_a, ser_b, shift_clk, zero_all_n, shift_ready_out;
  logic [GSP_STAGES-1:0] stage_outputs_out;
  logic [GSP_STAGES-1:0] exp_q = 8'h00;
  int failures = 0;
  int cmp_count = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  gsp_gpio u_gpio (.ref_clk_in(ref_clk_in), .ser_a_out(ser_a), .ser_b_out(ser_b),
    .shift_clk_out(shift_clk), .zero_all_n_out(zero_all_n));
  gsp_shifter u_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .ser_a_in(ser_a),
    .ser_b_in(ser_b), .shift_clk_in(shift_clk), .zero_all_n_in(zero_all_n),
    .stage_ready_in(stage_ready_in), .shift_ready_out(shift_ready_out),
    .stage_outputs_out(stage_outputs_out));
  ////////////////////////////////////////
  task automatic chk(input logic [GSP_STAGES-1:0] seen, input logic [GSP_STAGES-1:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk_in);
    #1;
  endtask
  task automatic shift_in(input logic a, input logic b);
    u_gpio.push(a, b);
    tick();
    exp_q = {exp_q[GSP_STAGES-2:0], a & b};
  endtask
  task automatic t_gate();
    for (int i = 0; i < 12; i++)
    begin
      shift_in(i[0], i[1] | i[2]);
      chk(stage_outputs_out, exp_q);
    end
    $display("gate done");
  endtask
  task automatic t_clear();
    shift_in(1'b1, 1'b1);
    u_gpio.zero_all_n_out = 1'b0;
    #5;
    chk(stage_outputs_out, 8'h00);
    tick();
    u_gpio.push(1'b1, 1'b1);
    tick();
    chk(stage_outputs_out, 8'h00);
    u_gpio.zero_all_n_out = 1'b1;
    exp_q = 8'h00;
    $display("clear done");
  endtask
  // The consumer stalls while the queue fills, so the chain must hold still.
  task automatic t_full();
    stage_ready_in = 1'b0;
    for (int i = 0; i < GSP_FIFO_DEPTH; i++)
      shift_in(i > 27, 1'b1);
    chk(stage_outputs_out, 8'h00);
    chk({7'h00, shift_ready_out}, 8'h00);
    u_gpio.push(1'b1, 1'b1);
    tick();
    stage_ready_in = 1'b1;
    for (int n = 0; n < 64 && stage_outputs_out !== exp_q; n++)
      tick();
    repeat (3) tick();
    chk(stage_outputs_out, exp_q);
    chk({7'h00, shift_ready_out}, 8'h01);
    $display("full done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    #1;
    rst_b_in = 1'b1;
    u_gpio.zero_all_n_out = 1'b1;
    tick();
    t_gate();
    t_clear();
    t_full();
    tally_and_finish();
  end
endmodule // gsp_shifter_bench
